// ==== rtl/mmd_defs.svh ====
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// ----------------------------------------------------------------
// Program space
// ----------------------------------------------------------------
`define MMD_PC_W          13
`define MMD_PWORD_W       14
`define MMD_RESET_VEC     13'h0000
`define MMD_INT_VEC       13'h0004
`define MMD_PM_WORDS_DEF  8192

// ----------------------------------------------------------------
// Data space
// ----------------------------------------------------------------
`define MMD_OFS_W         7
`define MMD_DADDR_W       9
`define MMD_STAT_BSH_BIT  6
`define MMD_STAT_BSL_BIT  5
`define MMD_SFR_LIMIT     7'h20
`define MMD_IND_OFS       7'h00
`define MMD_STATUS_OFS    7'h03
`define MMD_PTR_OFS       7'h04
`define MMD_MIRROR_LO     7'h70

`endif

// ==== rtl/mmd_pkg.sv ====
package mmd_pkg;
    // Region that a data access decodes to
    typedef enum logic [2:0] {
        MMD_REG_SFR    = 3'h1,
        MMD_REG_GPR    = 3'h2,
        MMD_REG_MIRROR = 3'h4
    } mmd_region_t;
endpackage

// ==== rtl/mmd_prog_mem.sv ====
`timescale 1ns/1ps
`include "mmd_defs.svh"

// Program store: one fetch port, one table-read port, registered reads
module mmd_prog_mem #(
    parameter int WORDS = `MMD_PM_WORDS_DEF,
    parameter int AW    = $clog2(WORDS)
) (
    // Clock
    input  wire logic                      core_clk,
    // Fetch port
    input  wire logic [AW-1:0]             fetch_addr,
    output logic      [`MMD_PWORD_W-1:0]   fetch_data,
    // Table read port
    input  wire logic [AW-1:0]             tbl_addr,
    output logic      [`MMD_PWORD_W-1:0]   tbl_data,
    // Load port
    input  wire logic                      load_en,
    input  wire logic [AW-1:0]             load_addr,
    input  wire logic [`MMD_PWORD_W-1:0]   load_data
);
    logic [`MMD_PWORD_W-1:0] mem [WORDS];  // Word array

    // Registered reads; two ports so fetch never waits on a table read
    always_ff @(posedge core_clk) begin
        if (load_en) begin
            mem[load_addr] <= load_data;
        end
        fetch_data <= mem[fetch_addr];
        tbl_data   <= mem[tbl_addr];
    end
endmodule

// ==== rtl/mmd_data_mem.sv ====
`timescale 1ns/1ps
`include "mmd_defs.svh"

// General purpose RAM for the data store, registered read
module mmd_data_mem #(
    parameter int DEPTH = 512,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic          core_clk,
    // Access port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];  // Byte array

    // Read first: a write cycle returns the old byte, read registered
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ==== rtl/mmd_bank_decoder.sv ====
`timescale 1ns/1ps
`include "mmd_defs.svh"

// ----------------------------------------------------------------
// Memory map and bank decoder
// ----------------------------------------------------------------
module mmd_bank_decoder
    import mmd_pkg::*;
#(
    parameter int PM_WORDS = `MMD_PM_WORDS_DEF,
    parameter int PM_AW    = $clog2(PM_WORDS)
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      srst,
    // Fetch side from the core
    input  wire logic                      fetch_adv,
    input  wire logic                      fetch_jump,
    input  wire logic [`MMD_PC_W-1:0]      jump_target,
    input  wire logic                      irq_take,
    output logic      [`MMD_PC_W-1:0]      pc_out,
    output logic      [`MMD_PWORD_W-1:0]   instr_out,
    // Program load
    input  wire logic                      pm_load_en,
    input  wire logic [`MMD_PC_W-1:0]      pm_load_addr,
    input  wire logic [`MMD_PWORD_W-1:0]   pm_load_data,
    // Table read of program memory
    input  wire logic                      tbl_req,
    input  wire logic [`MMD_PC_W-1:0]      tbl_addr,
    output logic                           tbl_valid,
    output logic      [`MMD_PWORD_W-1:0]   tbl_word,
    // Data operand side from the core
    input  wire logic                      dacc_req,
    input  wire logic                      dacc_wr,
    input  wire logic                      dacc_indirect,
    input  wire logic [`MMD_OFS_W-1:0]     dacc_ofs,
    input  wire logic [7:0]                dacc_wdata,
    output logic                           dacc_valid,
    output logic      [7:0]                dacc_rdata,
    output logic      [`MMD_DADDR_W-1:0]   dacc_addr,
    output logic                           dacc_is_sfr,
    output logic                           dacc_is_gpr,
    // Bank select state
    output logic                           bank_select_high,
    output logic                           bank_select_low
);
    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    // Map a full data address onto its physical cell; mirrored
    // SFRs and the shared RAM window collapse onto bank 0
    function automatic logic [`MMD_DADDR_W-1:0] phys_addr(input logic [`MMD_DADDR_W-1:0] a);
        logic [`MMD_OFS_W-1:0] o;
        o = a[`MMD_OFS_W-1:0];
        if (o == `MMD_IND_OFS || o == `MMD_STATUS_OFS || o == `MMD_PTR_OFS
            || o >= `MMD_MIRROR_LO) begin
            phys_addr = {2'b00, o};
        end else begin
            phys_addr = a;
        end
    endfunction

    // Region of an offset within a bank
    function automatic mmd_region_t region_of(input logic [`MMD_OFS_W-1:0] o);
        if (o >= `MMD_MIRROR_LO) begin
            region_of = MMD_REG_MIRROR;
        end else if (o < `MMD_SFR_LIMIT) begin
            region_of = MMD_REG_SFR;
        end else begin
            region_of = MMD_REG_GPR;
        end
    endfunction

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    logic [`MMD_PC_W-1:0] pc_r;    // Fetch address
    logic [`MMD_PC_W-1:0] pc_nxt;
    logic [PM_AW-1:0]     fetch_phys;
    logic [PM_AW-1:0]     tbl_phys;

    // Next fetch address; interrupt beats a jump, jump beats advance
    always_comb begin
        pc_nxt = pc_r;
        if (irq_take) begin
            pc_nxt = `MMD_INT_VEC;
        end else if (fetch_jump) begin
            pc_nxt = jump_target;
        end else if (fetch_adv) begin
            pc_nxt = pc_r + 13'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pc_r <= `MMD_RESET_VEC;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // Dropping upper bits folds high addresses onto real words
    assign fetch_phys = pc_r[PM_AW-1:0];
    assign tbl_phys   = tbl_addr[PM_AW-1:0];

    // Program store with its own port for the data path
    mmd_prog_mem #(.WORDS(PM_WORDS)) u_pm (
        .core_clk   (core_clk),
        .fetch_addr (fetch_phys),
        .fetch_data (instr_out),
        .tbl_addr   (tbl_phys),
        .tbl_data   (tbl_word),
        .load_en    (pm_load_en),
        .load_addr  (pm_load_addr[PM_AW-1:0]),
        .load_data  (pm_load_data)
    );

    // ------------------------------------------------------------
    // Output and table-read strobes
    // ------------------------------------------------------------
    logic [`MMD_PC_W-1:0] pc_out_r;
    logic [`MMD_PC_W-1:0] pc_out_nxt;
    logic                 tbl_valid_r;
    logic                 tbl_valid_nxt;

    // Address of the word now on instr_out
    always_comb begin
        pc_out_nxt    = pc_r;
        tbl_valid_nxt = tbl_req;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pc_out_r    <= `MMD_RESET_VEC;
            tbl_valid_r <= 1'b0;
        end else begin
            pc_out_r    <= pc_out_nxt;
            tbl_valid_r <= tbl_valid_nxt;
        end
    end

    assign pc_out    = pc_out_r;
    assign tbl_valid = tbl_valid_r;

    // ------------------------------------------------------------
    // Status bank bits and pointer register
    // ------------------------------------------------------------
    logic [7:0]              status_r;   // Bank bits live here
    logic [7:0]              status_nxt;
    logic [7:0]              ptr_r;      // indirect_pointer_register
    logic [7:0]              ptr_nxt;
    logic [`MMD_DADDR_W-1:0] full_addr;
    logic [`MMD_DADDR_W-1:0] phys;
    logic [`MMD_OFS_W-1:0]   eff_ofs;
    logic                    sel_h;
    logic                    sel_l;
    mmd_region_t             reg_kind;

    assign sel_h = status_r[`MMD_STAT_BSH_BIT];
    assign sel_l = status_r[`MMD_STAT_BSL_BIT];

    // Form the full address: direct or through the pointer
    always_comb begin
        if (dacc_indirect) begin
            // Status high bank bit picks the bank pair; pointer's top bit picks the bank within it
            full_addr = {sel_h, ptr_r};
        end else begin
            full_addr = {sel_h, sel_l, dacc_ofs};
        end
        eff_ofs  = full_addr[`MMD_OFS_W-1:0];
        phys     = phys_addr(full_addr);
        reg_kind = region_of(eff_ofs);
    end

    // Writes to the status and pointer cells, any mirror
    always_comb begin
        status_nxt = status_r;
        ptr_nxt    = ptr_r;
        if (dacc_req && dacc_wr && phys == {2'b00, `MMD_STATUS_OFS}) begin
            status_nxt = dacc_wdata;
        end
        if (dacc_req && dacc_wr && phys == {2'b00, `MMD_PTR_OFS}) begin
            ptr_nxt = dacc_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_r <= 8'h00;
            ptr_r    <= 8'h00;
        end else begin
            status_r <= status_nxt;
            ptr_r    <= ptr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Data store and answer
    // ------------------------------------------------------------
    logic [7:0]              ram_rdata;
    logic                    ram_wr;
    logic                    dv_r;
    logic                    dv_nxt;
    logic [`MMD_DADDR_W-1:0] da_r;
    logic [`MMD_DADDR_W-1:0] da_nxt;
    logic                    sfr_r;
    logic                    sfr_nxt;
    logic                    gpr_r;
    logic                    gpr_nxt;
    logic                    bh_r;
    logic                    bl_r;

    // Only RAM regions write the array; SPECIAL_FUNCTION_REGISTER cells live elsewhere
    assign ram_wr = dacc_req && dacc_wr && reg_kind != MMD_REG_SFR;

    mmd_data_mem #(.DEPTH(512)) u_dm (
        .core_clk (core_clk),
        .wr_en    (ram_wr),
        .addr     (phys),
        .wdata    (dacc_wdata),
        .rdata    (ram_rdata)
    );

    // Answer flags, one cycle after the request
    always_comb begin
        dv_nxt  = dacc_req;
        da_nxt  = dacc_req ? full_addr : da_r;
        sfr_nxt = dacc_req && reg_kind == MMD_REG_SFR;
        gpr_nxt = dacc_req && reg_kind != MMD_REG_SFR;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dv_r  <= 1'b0;
            da_r  <= '0;
            sfr_r <= 1'b0;
            gpr_r <= 1'b0;
            bh_r  <= 1'b0;
            bl_r  <= 1'b0;
        end else begin
            dv_r  <= dv_nxt;
            da_r  <= da_nxt;
            sfr_r <= sfr_nxt;
            gpr_r <= gpr_nxt;
            bh_r  <= status_nxt[`MMD_STAT_BSH_BIT];
            bl_r  <= status_nxt[`MMD_STAT_BSL_BIT];
        end
    end

    // Read data: RAM word for RAM regions, zero for SPECIAL_FUNCTION_REGISTER space
    assign dacc_rdata       = gpr_r ? ram_rdata : 8'h00;
    assign dacc_valid       = dv_r;
    assign dacc_addr        = da_r;
    assign dacc_is_sfr      = sfr_r;
    assign dacc_is_gpr      = gpr_r;
    assign bank_select_high = bh_r;
    assign bank_select_low  = bl_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    reset_vec_a: assert property ($past(srst) |-> pc_r == 13'h0000)
        else $error("fetch did not restart at zero");
    int_vec_a: assert property (irq_take |=> pc_r == 13'h0004)
        else $error("interrupt did not go to vector four");
    pc_inc_a: assert property (fetch_adv && !irq_take && !fetch_jump |=> pc_r == $past(pc_r) + 13'h0001)
        else $error("counter did not step by one");
    wrap_a: assert property (32'(fetch_phys) == 32'(pc_r) % PM_WORDS)
        else $error("fetch address not folded");
    direct_addr_a: assert property (dacc_req && !dacc_indirect
        |=> dacc_addr == {bank_select_high, bank_select_low, $past(dacc_ofs)} || $past(dacc_wr))
        else $error("direct address not bank over offset");
    bank_bits_a: assert property (dacc_req && dacc_wr && phys == 9'h003
        |=> bank_select_high == $past(dacc_wdata[6]) && bank_select_low == $past(dacc_wdata[5]))
        else $error("bank bits not taken from status");
    sfr_region_a: assert property (dacc_req |=> dacc_is_sfr == ($past(full_addr[6:0]) < 7'h20))
        else $error("SPECIAL_FUNCTION_REGISTER decode wrong");
    mirror_a: assert property (dacc_req && full_addr[6:0] == 7'h04 |-> phys == 9'h004)
        else $error("pointer not mirrored");
    tbl_resp_a: assert property (tbl_req |=> tbl_valid)
        else $error("table read not answered");
    indirect_a: assert property (dacc_req && dacc_indirect && !dacc_wr
        |=> dacc_addr[7:0] == $past(ptr_r))
        else $error("indirect address not from pointer");

    irq_cov: cover property (irq_take ##1 fetch_adv);
    bank3_cov: cover property (dacc_req && full_addr[8:7] == 2'b11);
    ind_cov: cover property (dacc_req && dacc_indirect && reg_kind == MMD_REG_GPR);
    both_cov: cover property (tbl_req && dacc_req && fetch_adv);
endmodule

// ==== dv/mmd_core_model.sv ====
`timescale 1ns/1ps
`include "mmd_defs.svh"

// ----------------------------------------------------------------
// Core side model: fetch control, program load, operand requests
// ----------------------------------------------------------------
// Every task is entered just after a falling edge and returns just
// after the falling edge that follows the taking rising edge.
module mmd_core_model (
    // Clock
    input  wire logic                 core_clk,
    // Fetch control
    output logic                      fetch_adv,
    output logic                      fetch_jump,
    output logic [`MMD_PC_W-1:0]      jump_target,
    output logic                      irq_take,
    // Program load
    output logic                      pm_load_en,
    output logic [`MMD_PC_W-1:0]      pm_load_addr,
    output logic [`MMD_PWORD_W-1:0]   pm_load_data,
    // Table read
    output logic                      tbl_req,
    output logic [`MMD_PC_W-1:0]      tbl_addr,
    // Operand access
    output logic                      dacc_req,
    output logic                      dacc_wr,
    output logic                      dacc_indirect,
    output logic [`MMD_OFS_W-1:0]     dacc_ofs,
    output logic [7:0]                dacc_wdata
);
    // Quiet bus at time zero
    initial begin
        {fetch_adv, fetch_jump, jump_target, irq_take} = '0;
        {pm_load_en, pm_load_addr, pm_load_data, tbl_req, tbl_addr} = '0;
        {dacc_req, dacc_wr, dacc_indirect, dacc_ofs, dacc_wdata} = '0;
    end

    // Write one program word; released data is inverted so a stale value never looks valid
    task automatic load(input logic [12:0] a, input logic [13:0] d);
        pm_load_en   = 1'b1;
        pm_load_addr = a;
        pm_load_data = d;
        @(negedge core_clk);
        pm_load_en   = 1'b0;
        pm_load_data = ~d;
    endtask

    // Jump, optionally with an interrupt taken in the same cycle
    task automatic jump(input logic [12:0] t, input logic irq);
        fetch_jump  = 1'b1;
        jump_target = t;
        irq_take    = irq;
        @(negedge core_clk);
        fetch_jump  = 1'b0;
        irq_take    = 1'b0;
        jump_target = ~t;
    endtask

    // Single step of the counter
    task automatic step();
        fetch_adv = 1'b1;
        @(negedge core_clk);
        fetch_adv = 1'b0;
    endtask

    // Program word read as data
    task automatic tbl(input logic [12:0] a);
        tbl_req  = 1'b1;
        tbl_addr = a;
        @(negedge core_clk);
        tbl_req  = 1'b0;
        tbl_addr = ~a;
    endtask

    // Operand access, with an optional fetch step in the same cycle
    task automatic acc(input logic wr, input logic ind, input logic [6:0] ofs,
                       input logic [7:0] wd, input logic adv);
        dacc_req      = 1'b1;
        dacc_wr       = wr;
        dacc_indirect = ind;
        dacc_ofs      = ofs;
        dacc_wdata    = wd;
        fetch_adv     = adv;
        @(negedge core_clk);
        dacc_req      = 1'b0;
        fetch_adv     = 1'b0;
        dacc_ofs      = ~ofs;
        dacc_wdata    = ~wd;
    endtask
endmodule

// ==== dv/mmd_bank_decoder_bench.sv ====
`timescale 1ns/1ps
`include "mmd_defs.svh"

module mmd_bank_decoder_bench;
    import mmd_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    // Half size store so that the wrap above the implemented range shows
    localparam int PM_WORDS = 4096;
    logic                      core_clk = 1'b0;
    logic                      srst     = 1'b1;
    logic                      fetch_adv, fetch_jump, irq_take, pm_load_en, tbl_req;
    logic                      dacc_req, dacc_wr, dacc_indirect;
    logic [`MMD_PC_W-1:0]      jump_target, pm_load_addr, tbl_addr, pc_out;
    logic [`MMD_PWORD_W-1:0]   pm_load_data, instr_out, tbl_word;
    logic [`MMD_OFS_W-1:0]     dacc_ofs;
    logic [7:0]                dacc_wdata, dacc_rdata;
    logic [`MMD_DADDR_W-1:0]   dacc_addr;
    logic                      tbl_valid, dacc_valid, dacc_is_sfr, dacc_is_gpr;
    logic                      bank_select_high, bank_select_low;
    int                        n_mismatch   = 0;
    int                        total_checks = 0;

    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;

    mmd_bank_decoder #(.PM_WORDS(PM_WORDS)) u_mmd_bank_decoder (
        .core_clk(core_clk), .srst(srst), .fetch_adv(fetch_adv), .fetch_jump(fetch_jump),
        .jump_target(jump_target), .irq_take(irq_take), .pc_out(pc_out), .instr_out(instr_out),
        .pm_load_en(pm_load_en), .pm_load_addr(pm_load_addr), .pm_load_data(pm_load_data),
        .tbl_req(tbl_req), .tbl_addr(tbl_addr), .tbl_valid(tbl_valid), .tbl_word(tbl_word),
        .dacc_req(dacc_req), .dacc_wr(dacc_wr), .dacc_indirect(dacc_indirect),
        .dacc_ofs(dacc_ofs), .dacc_wdata(dacc_wdata), .dacc_valid(dacc_valid),
        .dacc_rdata(dacc_rdata), .dacc_addr(dacc_addr), .dacc_is_sfr(dacc_is_sfr),
        .dacc_is_gpr(dacc_is_gpr), .bank_select_high(bank_select_high),
        .bank_select_low(bank_select_low));

    mmd_core_model u_mmd_core_model (
        .core_clk(core_clk), .fetch_adv(fetch_adv), .fetch_jump(fetch_jump),
        .jump_target(jump_target), .irq_take(irq_take), .pm_load_en(pm_load_en),
        .pm_load_addr(pm_load_addr), .pm_load_data(pm_load_data), .tbl_req(tbl_req),
        .tbl_addr(tbl_addr), .dacc_req(dacc_req), .dacc_wr(dacc_wr),
        .dacc_indirect(dacc_indirect), .dacc_ofs(dacc_ofs), .dacc_wdata(dacc_wdata));

    // ----------------------------------------------------------------
    // Compare, idle and verdict
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle();
        @(negedge core_clk);
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Pick a bank through the status byte, then leave a cycle for it to land
    task automatic set_bank(input logic [1:0] b);
        u_mmd_core_model.acc(1'b1, 1'b0, `MMD_STATUS_OFS, {1'b0, b, 5'h00}, 1'b0);
        idle();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_program();
        check(pc_out, 16'h0000);
        // A quiet cycle between loads keeps the enable from toggling twice in one step
        u_mmd_core_model.load(13'h0000, 14'h0A11);
        idle();
        u_mmd_core_model.load(13'h0004, 14'h0B44);
        idle();
        u_mmd_core_model.load(13'h0005, 14'h0C55);
        idle();
        u_mmd_core_model.load(13'h0FFF, 14'h2FFF);
        u_mmd_core_model.jump(13'h1005, 1'b0);
        idle();
        check(instr_out, 16'h0C55);
        u_mmd_core_model.jump(13'h1FFF, 1'b0);
        idle();
        check(pc_out, 16'h1FFF);
        check(instr_out, 16'h2FFF);
        // Top of the thirteen-bit space rolls over to zero
        u_mmd_core_model.step();
        idle();
        check(pc_out, 16'h0000);
        check(instr_out, 16'h0A11);
    endtask

    task automatic t_irq_and_table();
        // Interrupt wins over a jump in the same cycle
        u_mmd_core_model.jump(13'h0123, 1'b1);
        idle();
        check(pc_out, 16'h0004);
        check(instr_out, 16'h0B44);
        u_mmd_core_model.tbl(13'h1005);
        check(tbl_valid, 16'h0001);
        check(tbl_word, 16'h0C55);
        idle();
        check(tbl_valid, 16'h0000);
    endtask

    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            set_bank(b[1:0]);
            check({bank_select_high, bank_select_low}, b[15:0]);
            u_mmd_core_model.acc(1'b1, 1'b0, 7'h25, 8'hA0 + b[7:0], 1'b0);
            check(dacc_valid, 16'h0001);
            check(dacc_addr, {b[8:0], 7'h25});
            check({dacc_is_sfr, dacc_is_gpr}, 16'h0001);
            idle();
        end
        // Each bank keeps its own copy of the same offset
        for (int b = 0; b < 4; b++) begin
            set_bank(b[1:0]);
            u_mmd_core_model.acc(1'b0, 1'b0, 7'h25, 8'h00, 1'b0);
            check(dacc_rdata, 16'h00A0 + b[15:0]);
            idle();
        end
        set_bank(2'h2);
        u_mmd_core_model.acc(1'b0, 1'b0, 7'h10, 8'h00, 1'b0);
        check({dacc_is_sfr, dacc_is_gpr}, 16'h0002);
        check(dacc_rdata, 16'h0000);
        idle();
    endtask

    task automatic t_mirror_indirect();
        set_bank(2'h3);
        u_mmd_core_model.acc(1'b1, 1'b0, 7'h75, 8'h5A, 1'b0);
        idle();
        set_bank(2'h0);
        u_mmd_core_model.acc(1'b0, 1'b0, 7'h75, 8'h00, 1'b0);
        check(dacc_rdata, 16'h005A);
        idle();
        // Pointer A5h lands on bank 1 offset 25h
        u_mmd_core_model.acc(1'b1, 1'b0, `MMD_PTR_OFS, 8'hA5, 1'b0);
        idle();
        u_mmd_core_model.acc(1'b0, 1'b1, `MMD_IND_OFS, 8'h00, 1'b0);
        check(dacc_addr, 16'h00A5);
        check(dacc_rdata, 16'h00A1);
        idle();
    endtask

    task automatic t_concurrent_reset();
        u_mmd_core_model.jump(13'h0004, 1'b0);
        idle();
        // Fetch step and operand read share one cycle
        u_mmd_core_model.acc(1'b0, 1'b0, 7'h25, 8'h00, 1'b1);
        check(dacc_rdata, 16'h00A0);
        idle();
        check(pc_out, 16'h0005);
        check(instr_out, 16'h0C55);
        set_bank(2'h3);
        srst = 1'b1;
        idle();
        srst = 1'b0;
        idle();
        idle();
        check(pc_out, 16'h0000);
        check(instr_out, 16'h0A11);
        check({bank_select_high, bank_select_low}, 16'h0000);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        idle();
        t_program();
        t_irq_and_table();
        t_banks();
        t_mirror_indirect();
        t_concurrent_reset();
        summarize();
    end

    // The whole run is about eighty cycles; this allows ample margin
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end
endmodule
